// *** shared/qvr_pkg.sv ***
// package of constants and types for the quiet voltage-mode regulator
package qvr_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ        = 250;
  localparam int CLK_HZ         = 250_000_000;
  localparam int PWM_KHZ_0      = 25;
  localparam int PWM_KHZ_1      = 33;
  localparam int PWM_KHZ_2      = 42;
  localparam int PWM_KHZ_3      = 50;
  localparam int PER_W          = 14;
  localparam logic [PER_W-1:0] PWM_PER_0 = PER_W'(CLK_MHZ*1000/PWM_KHZ_0);
  localparam logic [PER_W-1:0] PWM_PER_1 = PER_W'(CLK_MHZ*1000/PWM_KHZ_1);
  localparam logic [PER_W-1:0] PWM_PER_2 = PER_W'(CLK_MHZ*1000/PWM_KHZ_2);
  localparam logic [PER_W-1:0] PWM_PER_3 = PER_W'(CLK_MHZ*1000/PWM_KHZ_3);
  localparam int SMPL_US_0      = 2;
  localparam int SMPL_US_1      = 3;
  localparam int SMPL_US_2      = 4;
  localparam int SMPL_US_3      = 5;
  localparam int SMPL_W         = 11;
  localparam logic [SMPL_W-1:0] SMPL_CYC_0 = SMPL_W'(SMPL_US_0*CLK_MHZ);
  localparam logic [SMPL_W-1:0] SMPL_CYC_1 = SMPL_W'(SMPL_US_1*CLK_MHZ);
  localparam logic [SMPL_W-1:0] SMPL_CYC_2 = SMPL_W'(SMPL_US_2*CLK_MHZ);
  localparam logic [SMPL_W-1:0] SMPL_CYC_3 = SMPL_W'(SMPL_US_3*CLK_MHZ);
  localparam int THR_STEP_HZ    = 2;
  // half-cycle length in clocks at frequency f: CLK_HZ / (2 f)
  localparam int HALF_W         = 28;

  // ==========================================================
  // reset values of the configuration fields
  localparam logic [1:0] RATE_RST   = 2'h0;
  localparam logic [1:0] SMPL_RST   = 2'h0;
  localparam logic [6:0] GAIN_RST   = 7'h00;
  localparam logic [2:0] DIV_RST    = 3'h0;
  localparam logic [7:0] THR_RST    = 8'hFF;
  localparam logic       EN_RST     = 1'b0;

  // ==========================================================
  // loop datapath widths
  localparam int CUR_W   = 12;
  localparam int DUTY_W  = 12;
  localparam int ACC_W   = 32;
  localparam int FRAC_W  = 9;

  // ==========================================================
  // types
  typedef struct packed {
    logic       quiet_mode_enable;
    logic [1:0] quiet_pwm_rate_select;
    logic [1:0] zero_cross_sample_time;
    logic [6:0] loop_prop_gain;
    logic [6:0] loop_integ_gain;
    logic [2:0] prop_gain_divider;
    logic [2:0] integ_gain_divider;
    logic [7:0] exit_frequency_threshold;
  } qvr_cfg_t;

  typedef struct packed {
    logic signed [CUR_W-1:0] target;
    logic signed [CUR_W-1:0] sensed;
  } qvr_coil_t;

  typedef enum logic [1:0] {
    QVR_FALLBACK = 2'b00,
    QVR_ARMING   = 2'b01,
    QVR_QUIET    = 2'b10
  } qvr_state_t;

  // divider code to right-shift count; 110b is divide by one
  function automatic logic [3:0] div_shift(input logic [2:0] code);
    case (code)
      3'h0:    div_shift = 4'h5;
      3'h1:    div_shift = 4'h6;
      3'h2:    div_shift = 4'h7;
      3'h3:    div_shift = 4'h8;
      3'h4:    div_shift = 4'h9;
      3'h5:    div_shift = 4'h4;
      3'h6:    div_shift = 4'h0;
      default: div_shift = 4'h5;
    endcase
  endfunction

endpackage

// *** design/qvr_pi_coil.sv ***
// discrete PI controller for one coil, updated once per PWM period
`timescale 1ns/10ps
module qvr_pi_coil (
  input  wire logic                       clk_in,
  input  wire logic                       rst_b_in,
  input  wire logic                       update_in,
  input  wire logic                       run_in,
  input  wire qvr_pkg::qvr_coil_t         coil_in,
  input  wire logic [6:0]                 kp_in,
  input  wire logic [6:0]                 ki_in,
  input  wire logic [3:0]                 kp_shift_in,
  input  wire logic [3:0]                 ki_shift_in,
  output logic signed [qvr_pkg::DUTY_W-1:0] duty_out
);
  import qvr_pkg::*;

  logic signed [ACC_W-1:0]  integ;
  logic signed [ACC_W-1:0]  next_integ;
  logic signed [DUTY_W-1:0] next_duty;
  logic signed [CUR_W:0]    err;
  logic signed [ACC_W-1:0]  p_term;
  logic signed [ACC_W-1:0]  i_inc;
  logic signed [ACC_W-1:0]  sum;
  localparam logic signed [ACC_W-1:0] DMAX = ACC_W'((1 << (DUTY_W-1)) - 1);

  // integrator holds FRAC_W extra fraction bits so a gain of 1/512 is kept
  always_comb begin
    err        = $signed({coil_in.target[CUR_W-1], coil_in.target})
               - $signed({coil_in.sensed[CUR_W-1], coil_in.sensed});
    p_term     = (ACC_W'(err) * $signed({1'b0, kp_in})) >>> kp_shift_in;
    i_inc      = ((ACC_W'(err) * $signed({1'b0, ki_in})) <<< FRAC_W)
               >>> ki_shift_in;
    next_integ = integ;
    next_duty  = duty_out;
    sum        = '0;
    if (!run_in) begin
      next_integ = '0;
      next_duty  = '0;
    end else if (update_in) begin
      // pole at origin from accumulation, zero from ki/kp ratio
      next_integ = integ + i_inc;
      if (next_integ > (DMAX <<< FRAC_W)) next_integ = DMAX <<< FRAC_W;
      if (next_integ < -(DMAX <<< FRAC_W)) next_integ = -(DMAX <<< FRAC_W);
      sum = p_term + (next_integ >>> FRAC_W);
      if (sum > DMAX) sum = DMAX;
      if (sum < -DMAX) sum = -DMAX;
      next_duty = DUTY_W'(sum);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      integ    <= '0;
      duty_out <= '0;
    end else begin
      integ    <= next_integ;
      duty_out <= next_duty;
    end
  end

endmodule

// *** design/qvr_zero_cross.sv ***
// zero-crossing detector with sampling window and half-cycle timer
`timescale 1ns/10ps
module qvr_zero_cross (
  input  wire logic                          clk_in,
  input  wire logic                          rst_b_in,
  input  wire logic signed [qvr_pkg::CUR_W-1:0] sensed_in,
  input  wire logic [qvr_pkg::SMPL_W-1:0]    window_in,
  output logic                               cross_out,
  output logic [qvr_pkg::HALF_W-1:0]         half_len_out
);
  import qvr_pkg::*;

  logic              sign;
  logic              next_sign;
  logic              primed;
  logic              next_primed;
  logic [SMPL_W-1:0] dwell;
  logic [SMPL_W-1:0] next_dwell;
  logic [HALF_W-1:0] timer;
  logic [HALF_W-1:0] next_timer;
  logic [HALF_W-1:0] next_len;
  logic              next_cross;

  // a new polarity must hold for the whole window before it counts,
  // which keeps distortion near zero from giving false crossings
  always_comb begin
    next_sign  = sign;
    next_cross = 1'b0;
    next_len   = half_len_out;
    next_timer = (&timer) ? timer : timer + 1'b1;
    next_dwell = '0;
    next_primed = 1'b1;
    if (!primed) begin
      // first sample after reset only learns the polarity; a reset
      // value unlike the idle current would fake a crossing
      next_sign = sensed_in[CUR_W-1];
    end else if (sensed_in[CUR_W-1] != sign) begin
      next_dwell = dwell + 1'b1;
      if (dwell >= window_in) begin
        next_sign  = sensed_in[CUR_W-1];
        next_cross = 1'b1;
        next_len   = timer;
        next_timer = '0;
        next_dwell = '0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sign         <= 1'b0;
      primed       <= 1'b0;
      dwell        <= '0;
      timer        <= '0;
      cross_out    <= 1'b0;
      half_len_out <= '1;
    end else begin
      sign         <= next_sign;
      primed       <= next_primed;
      dwell        <= next_dwell;
      timer        <= next_timer;
      cross_out    <= next_cross;
      half_len_out <= next_len;
    end
  end

endmodule

// *** design/qvr_regulator.sv ***
// quiet voltage-mode PWM regulator top for two coils
`timescale 1ns/10ps
module qvr_regulator (
  input  wire logic                       clk_in,
  input  wire logic                       rst_b_in,
  input  wire qvr_pkg::qvr_cfg_t          cfg_in,
  input  wire qvr_pkg::qvr_coil_t         coil_a_in,
  input  wire qvr_pkg::qvr_coil_t         coil_b_in,
  input  wire logic                       moving_in,
  output logic                            quiet_active_out,
  output logic signed [qvr_pkg::DUTY_W-1:0] duty_a_out,
  output logic signed [qvr_pkg::DUTY_W-1:0] duty_b_out,
  output logic                            pwm_a_out,
  output logic                            pwm_b_out,
  output logic                            pwm_a_neg_out,
  output logic                            pwm_b_neg_out,
  output logic                            open_load_en_out,
  output logic                            stall_det_en_out,
  output logic                            spread_en_out,
  output logic                            off_time_en_out,
  output logic                            over_thr_out
);
  import qvr_pkg::*;

  // ==========================================================
  // configuration decode
  logic [PER_W-1:0]  pwm_per;
  logic [SMPL_W-1:0] smpl_win;
  logic [HALF_W-1:0] thr_half;

  always_comb begin
    case (cfg_in.quiet_pwm_rate_select)
      2'h0:    pwm_per = PWM_PER_0;
      2'h1:    pwm_per = PWM_PER_1;
      2'h2:    pwm_per = PWM_PER_2;
      2'h3:    pwm_per = PWM_PER_3;
      default: pwm_per = PWM_PER_0;
    endcase
    case (cfg_in.zero_cross_sample_time)
      2'h0:    smpl_win = SMPL_CYC_0;
      2'h1:    smpl_win = SMPL_CYC_1;
      2'h2:    smpl_win = SMPL_CYC_2;
      2'h3:    smpl_win = SMPL_CYC_3;
      default: smpl_win = SMPL_CYC_0;
    endcase
    // half-cycle length at threshold frequency; code 0 never exits
    if (cfg_in.exit_frequency_threshold == 8'h00)
      thr_half = '0;
    else
      thr_half = HALF_W'(CLK_HZ / (2 * THR_STEP_HZ)
               / int'(cfg_in.exit_frequency_threshold));
  end

  // ==========================================================
  // PWM carrier, one period sets the loop update rate
  logic [PER_W-1:0] pwm_cnt;
  logic [PER_W-1:0] next_pwm_cnt;
  logic             period_end;

  assign period_end = (pwm_cnt >= pwm_per - 1'b1);

  always_comb begin
    next_pwm_cnt = period_end ? '0 : pwm_cnt + 1'b1;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwm_cnt <= '0;
    end else begin
      pwm_cnt <= next_pwm_cnt;
    end
  end

  // ==========================================================
  // zero-crossing detection per coil
  logic              cross_a;
  logic              cross_b;
  logic [HALF_W-1:0] half_a;

  qvr_zero_cross u_zc_a (
    .clk_in       (clk_in),
    .rst_b_in     (rst_b_in),
    .sensed_in    (coil_a_in.sensed),
    .window_in    (smpl_win),
    .cross_out    (cross_a),
    .half_len_out (half_a)
  );

  qvr_zero_cross u_zc_b (
    .clk_in       (clk_in),
    .rst_b_in     (rst_b_in),
    .sensed_in    (coil_b_in.sensed),
    .window_in    (smpl_win),
    .cross_out    (cross_b),
    .half_len_out ()
  );

  // ==========================================================
  // mode control
  qvr_state_t state;
  qvr_state_t next_state;
  logic       seen_a;
  logic       seen_b;
  logic       next_seen_a;
  logic       next_seen_b;
  logic       over;
  logic       next_over;

  // a short half-cycle means a high electrical frequency; the compare
  // runs only at coil A crossings so the decision has full hysteresis
  // of one half-cycle and cannot chatter inside a half-cycle
  always_comb begin
    next_over = over;
    if (cross_a) next_over = (half_a < thr_half);
  end

  always_comb begin
    next_state  = state;
    next_seen_a = seen_a | cross_a;
    next_seen_b = seen_b | cross_b;
    case (state)
      QVR_FALLBACK: begin
        next_seen_a = 1'b0;
        next_seen_b = 1'b0;
        if (cfg_in.quiet_mode_enable) next_state = QVR_ARMING;
      end
      QVR_ARMING: begin
        if (!cfg_in.quiet_mode_enable) begin
          next_state = QVR_FALLBACK;
        end else if (next_seen_a && next_seen_b && cross_a && !next_over) begin
          // entry lands on a coil A crossing, a half-cycle edge
          next_state = QVR_QUIET;
        end
      end
      QVR_QUIET: begin
        if (!cfg_in.quiet_mode_enable) begin
          next_state = QVR_FALLBACK;
        end else if (next_over) begin
          // re-arm; a crossing in this very cycle still counts as seen
          next_state  = QVR_ARMING;
          next_seen_a = cross_a;
          next_seen_b = cross_b;
        end
      end
      default: next_state = QVR_FALLBACK;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state  <= QVR_FALLBACK;
      seen_a <= 1'b0;
      seen_b <= 1'b0;
      over   <= 1'b0;
    end else begin
      state  <= next_state;
      seen_a <= next_seen_a;
      seen_b <= next_seen_b;
      over   <= next_over;
    end
  end

  // exit is combinational so the fallback takes over in the same cycle
  assign quiet_active_out = (state == QVR_QUIET) &&
                            cfg_in.quiet_mode_enable && !next_over;
  assign over_thr_out     = over;

  // ==========================================================
  // feature gating while quiet mode is active
  assign open_load_en_out = !quiet_active_out || moving_in;
  assign stall_det_en_out = !quiet_active_out;
  assign spread_en_out    = !quiet_active_out;
  assign off_time_en_out  = !quiet_active_out;

  // ==========================================================
  // per-coil PI loops; gains used directly as stored
  logic [3:0] kp_sh;
  logic [3:0] ki_sh;

  assign kp_sh = div_shift(cfg_in.prop_gain_divider);
  assign ki_sh = div_shift(cfg_in.integ_gain_divider);

  qvr_pi_coil u_pi_a (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .update_in   (period_end),
    .run_in      (quiet_active_out),
    .coil_in     (coil_a_in),
    .kp_in       (cfg_in.loop_prop_gain),
    .ki_in       (cfg_in.loop_integ_gain),
    .kp_shift_in (kp_sh),
    .ki_shift_in (ki_sh),
    .duty_out    (duty_a_out)
  );

  qvr_pi_coil u_pi_b (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .update_in   (period_end),
    .run_in      (quiet_active_out),
    .coil_in     (coil_b_in),
    .kp_in       (cfg_in.loop_prop_gain),
    .ki_in       (cfg_in.loop_integ_gain),
    .kp_shift_in (kp_sh),
    .ki_shift_in (ki_sh),
    .duty_out    (duty_b_out)
  );

  // ==========================================================
  // duty to bridge drive: magnitude against carrier, sign to polarity
  logic [DUTY_W-1:0] mag_a;
  logic [DUTY_W-1:0] mag_b;
  logic              next_pwm_a;
  logic              next_pwm_b;

  always_comb begin
    mag_a = duty_a_out[DUTY_W-1] ? DUTY_W'(-duty_a_out) : DUTY_W'(duty_a_out);
    mag_b = duty_b_out[DUTY_W-1] ? DUTY_W'(-duty_b_out) : DUTY_W'(duty_b_out);
    // duty scale: full magnitude maps onto the full period
    next_pwm_a = quiet_active_out &&
      ({2'b00, pwm_cnt, {(DUTY_W-1){1'b0}}} <
       {{(PER_W+1){1'b0}}, mag_a} * {{(DUTY_W+1){1'b0}}, pwm_per});
    next_pwm_b = quiet_active_out &&
      ({2'b00, pwm_cnt, {(DUTY_W-1){1'b0}}} <
       {{(PER_W+1){1'b0}}, mag_b} * {{(DUTY_W+1){1'b0}}, pwm_per});
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwm_a_out     <= 1'b0;
      pwm_b_out     <= 1'b0;
      pwm_a_neg_out <= 1'b0;
      pwm_b_neg_out <= 1'b0;
    end else begin
      pwm_a_out     <= next_pwm_a;
      pwm_b_out     <= next_pwm_b;
      pwm_a_neg_out <= duty_a_out[DUTY_W-1];
      pwm_b_neg_out <= duty_b_out[DUTY_W-1];
    end
  end

endmodule

// *** verif/qvr_regulator_checker.sv ***
// port-level assertion checker for the quiet regulator
`timescale 1ns/10ps
module qvr_regulator_checker (
  input  wire logic                         clk_in,
  input  wire logic                         rst_b_in,
  input  wire qvr_pkg::qvr_cfg_t            cfg_in,
  input  wire logic                         moving_in,
  input  wire logic                         quiet_active_out,
  input  wire logic signed [qvr_pkg::DUTY_W-1:0] duty_a_out,
  input  wire logic                         pwm_a_out,
  input  wire logic                         open_load_en_out,
  input  wire logic                         stall_det_en_out,
  input  wire logic                         spread_en_out,
  input  wire logic                         off_time_en_out,
  input  wire logic                         over_thr_out
);
  import qvr_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ==========================================================
  // features masked while quiet, open-load only while moving
  property p_open_load;
    quiet_active_out |-> open_load_en_out == moving_in;
  endproperty
  a_open_load: assert property (p_open_load)
    else $error("open-load enable wrong in quiet mode");
  property p_stall;
    quiet_active_out |-> !stall_det_en_out;
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall detection left on in quiet mode");
  property p_spread;
    quiet_active_out |-> !spread_en_out;
  endproperty
  a_spread: assert property (p_spread)
    else $error("spread spectrum left on in quiet mode");
  property p_off_time;
    quiet_active_out |-> !off_time_en_out;
  endproperty
  a_off_time: assert property (p_off_time)
    else $error("fixed off-time active in quiet mode");
  // ==========================================================
  // mode changes
  property p_exit_now;
    over_thr_out && cfg_in.exit_frequency_threshold != 8'h00
      |-> !quiet_active_out;
  endproperty
  a_exit_now: assert property (p_exit_now)
    else $error("quiet mode kept above threshold");
  property p_disable;
    !cfg_in.quiet_mode_enable |-> !quiet_active_out;
  endproperty
  a_disable: assert property (p_disable)
    else $error("quiet mode kept after enable cleared");
  property p_entry;
    $rose(quiet_active_out)
      |-> $past(cfg_in.quiet_mode_enable, 2) && !over_thr_out;
  endproperty
  a_entry: assert property (p_entry)
    else $error("quiet mode entered without arming");
  // ==========================================================
  // duty behaviour: idle after 3 cycles not quiet, steady for 8 cycles after a change
  property p_idle_duty;
    !quiet_active_out [*3] |-> duty_a_out == 12'sh000 && !pwm_a_out;
  endproperty
  a_idle_duty: assert property (p_idle_duty)
    else $error("duty drive present outside quiet mode");
  property p_duty_hold;
    quiet_active_out && $past(quiet_active_out) && $changed(duty_a_out)
      |=> ($stable(duty_a_out) || !quiet_active_out) [*8];
  endproperty
  a_duty_hold: assert property (p_duty_hold)
    else $error("duty changed twice within one period");
endmodule
bind qvr_regulator qvr_regulator_checker u_chk (
  .clk_in           (clk_in),
  .rst_b_in         (rst_b_in),
  .cfg_in           (cfg_in),
  .moving_in        (moving_in),
  .quiet_active_out (quiet_active_out),
  .duty_a_out       (duty_a_out),
  .pwm_a_out        (pwm_a_out),
  .open_load_en_out (open_load_en_out),
  .stall_det_en_out (stall_det_en_out),
  .spread_en_out    (spread_en_out),
  .off_time_en_out  (off_time_en_out),
  .over_thr_out     (over_thr_out)
);

// *** verif/qvr_coil_model.sv ***
// two coils behind the bridges: square-wave sensed currents
`timescale 1ns/10ps
module qvr_coil_model (
  input  wire logic                          clk_in,
  input  wire logic                          rst_b_in,
  input  wire logic                          run_in,
  input  wire logic [15:0]                   half_in,
  input  wire logic signed [qvr_pkg::CUR_W-1:0] target_in,
  output qvr_pkg::qvr_coil_t                 coil_a_out,
  output qvr_pkg::qvr_coil_t                 coil_b_out
);
  import qvr_pkg::*;
  logic [15:0] cnt;
  logic        pol_a;
  logic        pol_b;
  // coil b flips mid half-cycle so the two crossings never coincide
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt <= 16'h0000;
      pol_a <= 1'b0;
      pol_b <= 1'b0;
    end else if (run_in) begin
      cnt <= (cnt >= half_in - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
      if (cnt == half_in - 16'h0001) pol_a <= !pol_a;
      if (cnt == (half_in >> 1)) pol_b <= !pol_b;
    end
  end
  // current magnitude kept at one step so the error is near the target
  assign coil_a_out = {target_in, (pol_a ? 12'h001 : 12'hFFF)};
  assign coil_b_out = {-target_in, (pol_b ? 12'h001 : 12'hFFF)};
endmodule

// *** verif/tb_top.sv ***
// self-checking testbench for the quiet regulator
`timescale 1ns/10ps
module tb_top;
  import qvr_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  qvr_cfg_t cfg;
  qvr_coil_t coil_a;
  qvr_coil_t coil_b;
  logic moving = 1'b0;
  logic run = 1'b0;
  logic [15:0] half = 16'h03E8;
  logic signed [CUR_W-1:0] target = 12'sh3E8;
  logic quiet, pwm_a, pwm_b, neg_a, neg_b, ol_en, st_en, ss_en, ot_en, ovr;
  logic signed [DUTY_W-1:0] duty_a, duty_b;
  int fail_count = 0;
  int checked = 0;
  // ==========================================================
  // clock, model and device
  always #2 clk_in = !clk_in;
  qvr_coil_model u_model (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .run_in(run), .half_in(half), .target_in(target),
    .coil_a_out(coil_a), .coil_b_out(coil_b));
  qvr_regulator DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .cfg_in(cfg),
    .coil_a_in(coil_a), .coil_b_in(coil_b), .moving_in(moving),
    .quiet_active_out(quiet), .duty_a_out(duty_a), .duty_b_out(duty_b),
    .pwm_a_out(pwm_a), .pwm_b_out(pwm_b), .pwm_a_neg_out(neg_a),
    .pwm_b_neg_out(neg_b), .open_load_en_out(ol_en),
    .stall_det_en_out(st_en), .spread_en_out(ss_en),
    .off_time_en_out(ot_en), .over_thr_out(ovr));
  // ==========================================================
  // helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // bounded wait for the quiet flag to reach a level
  task automatic wait_q(input logic v, input int lim);
    for (int i = 0; i < lim && quiet !== v; i++) step(1);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    check(quiet, 0);
    check({ol_en, st_en, ss_en, ot_en}, 4'hF);
    check(32'(duty_a), 0);
  endtask
  // no entry without crossings, nor with crossings shorter than window
  task automatic t_entry;
    cfg.quiet_mode_enable = 1'b1;
    cfg.zero_cross_sample_time = 2'h3;
    cfg.quiet_pwm_rate_select = 2'h3;
    step(2000);
    check(quiet, 0);
    run = 1'b1;
    step(4000);
    check(quiet, 0);
    cfg.zero_cross_sample_time = 2'h0;
    wait_q(1'b1, 8000);
    check(quiet, 1);
    check({st_en, ss_en, ot_en}, 3'h0);
    check(ol_en, 0);
    moving = 1'b1;
    step(1);
    check(ol_en, 1);
    moving = 1'b0;
  endtask
  // each divider code but 7 and each pwm rate with integral gain zero
  task automatic t_gain;
    int kp[7] = '{64, 127, 127, 127, 127, 32, 2};
    int sh[7] = '{5, 6, 7, 8, 9, 4, 0};
    int per[4] = '{PWM_PER_0, PWM_PER_1, PWM_PER_2, PWM_PER_3};
    int e1, e2, n;
    for (int i = 0; i < 7; i++) begin
      cfg.loop_prop_gain = 7'(kp[i]);
      cfg.prop_gain_divider = 3'(i);
      cfg.quiet_pwm_rate_select = (i < 4) ? 2'(i) : 2'h3;
      // the rise-to-rise wait spans one full period, so a loop
      // update with the new settings has landed before duty is read
      if (i < 4) begin
        for (n = 0; n < 12000 && pwm_a !== 1'b0; n++) step(1);
        for (n = 0; n < 12000 && pwm_a !== 1'b1; n++) step(1);
        for (n = 0; n < 12000 && pwm_a !== 1'b0; n++) step(1);
        for (; n < 12000 && pwm_a !== 1'b1; n++) step(1);
        check(n, per[i]);
      end else begin
        step(per[3] + 20);
      end
      e1 = (999 * kp[i]) >>> sh[i];
      e2 = (1001 * kp[i]) >>> sh[i];
      check(32'(duty_a), (32'(duty_a) === e1) ? e1 : e2);
    end
    check({neg_a, neg_b}, 2'h1);
  endtask
  // integral only: duty winds up to full scale within a few periods
  task automatic t_integ;
    cfg.loop_prop_gain = 7'h00;
    cfg.loop_integ_gain = 7'h40;
    cfg.integ_gain_divider = 3'h0;
    step(2 * PWM_PER_3 + 20);
    check(32'(duty_a), 2047);
    check(32'(duty_b), -2047);
  endtask
  // fast coil frequency forces exit; threshold zero lets it back in
  task automatic t_exit;
    cfg.exit_frequency_threshold = 8'hFF;
    wait_q(1'b0, 3000);
    check(quiet, 0);
    step(1);
    check(ovr, 1);
    cfg.exit_frequency_threshold = 8'h00;
    wait_q(1'b1, 5000);
    check(quiet, 1);
    cfg.quiet_mode_enable = 1'b0;
    #1;
    check(quiet, 0);
    check(st_en, 1);
    step(4);
    check(32'(duty_a), 0);
    check(32'(duty_b), 0);
    check({pwm_a, pwm_b}, 2'h0);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    cfg = '{EN_RST, RATE_RST, SMPL_RST, GAIN_RST, GAIN_RST,
            DIV_RST, DIV_RST, 8'h00};
    step(6);
    rst_b_in = 1'b1;
    step(1);
    t_reset();
    t_entry();
    t_gain();
    t_integ();
    t_exit();
    conclude();
  end
  initial begin
    #480000;
    fail_count++;
    conclude();
  end
endmodule
